// ---- tmra_core.sv ----
// Register file, limit compare, conversion pacing and alarm latch.
// Every output is registered, so answers trail requests by a cycle.
// Assumes a byte-level engine decodes the two-wire bus and alert
// response address; the converter reports results by a done pulse.
`timescale 1ns/10ps
`default_nettype none
module tmra_core #(
  parameter int unsigned FAST_CYCLES = tmra_pkg::FAST_PERIOD_CYC,
  parameter logic [7:0]  MAKER_ID    = 8'h5A, // Arbitrary value
  parameter logic [7:0]  REVISION_ID = 8'h01  // Arbitrary value
) (
  input  wire logic       core_clk,    // Core clock
  input  wire logic       rst,         // Synchronous reset, high
  input  wire logic       busWrValid,  // Write byte strobe
  input  wire logic       busWrFirst,  // Byte is first of a write
  input  wire logic [7:0] busWrData,   // Write byte
  input  wire logic       busRdReq,    // Read byte request
  output logic      [7:0] busRdData,   // Read byte
  output logic            busRdValid,  // Read byte valid pulse
  input  wire logic       araReq,      // Alert response read
  output logic            araValid,    // Address answer pulse
  output logic      [6:0] araAddr,     // Own device address
  output logic            adcStart,    // Conversion start pulse
  input  wire logic       adcDone,     // Conversion done pulse
  input  wire logic [7:0] adcLocal,    // Local result
  input  wire logic [7:0] adcRemote,   // Remote result
  input  wire logic       adcOpen,     // Remote junction open
  input  wire logic       sleep_pin_n, // Standby pin, low active
  input  wire logic [1:0] addrStrap,   // Address strap level
  output logic            alertPinOut, // Alarm pin drive level
  output logic            alertPinOe   // Alarm pin pull enable
);
  localparam int NF = tmra_pkg::NUM_FLAGS;

  // Register state
  logic [7:0] ptr_q;
  logic [7:0] localVal_q;
  logic [7:0] remoteVal_q;
  logic [7:0] cfg_q;
  logic [7:0] rate_q;
  logic [7:0] localHi_q;
  logic [7:0] localLo_q;
  logic [7:0] remoteHi_q;
  logic [7:0] remoteLo_q;
  logic       open_q;
  logic [NF-1:0] flags;
  logic       latch_q;
  logic       servicePend_q;
  logic       oneShot_q;
  logic       strapDone_q;
  logic [6:0] devAddr_q;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  tmra_pkg::tmra_conv_state_t state_q;
  tmra_pkg::tmra_conv_state_t state_d;

  // Bus byte decode
  wire ptrWr  = busWrValid & busWrFirst;
  wire dataWr = busWrValid & ~busWrFirst;
  // Writes land only on write addresses
  wire wrCfg   = dataWr & (ptr_q == tmra_pkg::WR_CFG);
  wire wrRate  = dataWr & (ptr_q == tmra_pkg::WR_RATE);
  wire wrLHi   = dataWr & (ptr_q == tmra_pkg::WR_LOCAL_HI);
  wire wrLLo   = dataWr & (ptr_q == tmra_pkg::WR_LOCAL_LO);
  wire wrRHi   = dataWr & (ptr_q == tmra_pkg::WR_REMOTE_HI);
  wire wrRLo   = dataWr & (ptr_q == tmra_pkg::WR_REMOTE_LO);
  wire wrShot  = dataWr & (ptr_q == tmra_pkg::WR_ONE_SHOT);
  // Reserved codes would stall pacing, so clamp them
  wire [7:0] rateIn = (busWrData > tmra_pkg::RATE_MAX) ?
                      tmra_pkg::RATE_MAX : busWrData;

  // Mode decode: either control forces standby
  wire cfgStandby = cfg_q[tmra_pkg::CFG_SLEEP_PIN_N_BIT];
  wire pinStandby = ~sleep_pin_n;
  wire standby    = cfgStandby | pinStandby;
  wire busy       = (state_q == tmra_pkg::CONV_BUSY);

  // Limit compares, signed and strict
  wire lHiCause = $signed(localVal_q) > $signed(localHi_q);
  wire lLoCause = $signed(localVal_q) < $signed(localLo_q);
  wire rHiCause = $signed(remoteVal_q) > $signed(remoteHi_q);
  wire rLoCause = $signed(remoteVal_q) < $signed(remoteLo_q);
  // Index i maps onto status bit i+2
  wire [NF-1:0] cause = {
    lHiCause,
    lLoCause,
    rHiCause,
    rLoCause,
    open_q
  };
  wire statusRd = busRdReq & (ptr_q == tmra_pkg::RD_STATUS);

  // Alert response is taken only while the pin is pulled
  wire araTaken = araReq & alertPinOe;

  // Strap level to own address; both upper levels mean tied high
  wire [6:0] strapAddr =
    (addrStrap == tmra_pkg::STRAP_GND) ? tmra_pkg::DEV_ADDR_GND :
    (addrStrap == tmra_pkg::STRAP_NC)  ? tmra_pkg::DEV_ADDR_NC  :
    tmra_pkg::DEV_ADDR_VDD;

  // Status byte: busy, five flags, reserved zeros
  wire [7:0] statusByte = {busy, flags, 2'b00};

  // Read selection; write-only addresses read invalid
  wire [7:0] rdMux =
    (ptr_q == tmra_pkg::RD_LOCAL_VAL)  ? localVal_q  :
    (ptr_q == tmra_pkg::RD_REMOTE_VAL) ? remoteVal_q :
    (ptr_q == tmra_pkg::RD_STATUS)     ? statusByte  :
    (ptr_q == tmra_pkg::RD_CFG)        ? cfg_q       :
    (ptr_q == tmra_pkg::RD_RATE)       ? rate_q      :
    (ptr_q == tmra_pkg::RD_LOCAL_HI)   ? localHi_q   :
    (ptr_q == tmra_pkg::RD_LOCAL_LO)   ? localLo_q   :
    (ptr_q == tmra_pkg::RD_REMOTE_HI)  ? remoteHi_q  :
    (ptr_q == tmra_pkg::RD_REMOTE_LO)  ? remoteLo_q  :
    (ptr_q == tmra_pkg::RD_MAKER)      ? MAKER_ID    :
    (ptr_q == tmra_pkg::RD_REVISION)   ? REVISION_ID :
    tmra_pkg::RD_INVALID;

  // Pacing period doubles per code step below 07h
  wire [2:0]  shiftAmt = 3'(3'h7 - rate_q[tmra_pkg::RATE_W-1:0]);
  wire [31:0] period   = FAST_CYCLES[31:0] << shiftAmt;
  wire        cntZero  = (cnt_q == 32'h0000_0000);
  wire        runDue   = ~standby & cntZero;
  wire        startReq = ~busy & (runDue | oneShot_q);

  // Named strobes for the processes below
  wire        shotArm  = wrShot & standby;
  wire        loadRes  = busy & adcDone;
  wire        latchClr = servicePend_q & ~|cause;
  wire        pullD    = latch_q & ~cfg_q[tmra_pkg::CFG_MASK_BIT];

  // Pointer register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ptr_q <= tmra_pkg::PTR_RST;
    end else if (ptrWr) begin
      ptr_q <= busWrData;
    end
  end

  // Configuration; reserved low bits always read zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_q <= tmra_pkg::CFG_RST;
    end else if (wrCfg) begin
      cfg_q <= busWrData & 8'hC0;
    end
  end

  // Rate select, clamped before it is stored
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rate_q <= tmra_pkg::RATE_RST;
    end else if (wrRate) begin
      rate_q <= rateIn;
    end
  end

  // Limit registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      localHi_q  <= tmra_pkg::HI_RST;
      localLo_q  <= tmra_pkg::LO_RST;
      remoteHi_q <= tmra_pkg::HI_RST;
      remoteLo_q <= tmra_pkg::LO_RST;
    end else begin
      if (wrLHi) begin
        localHi_q <= busWrData;
      end
      if (wrLLo) begin
        localLo_q <= busWrData;
      end
      if (wrRHi) begin
        remoteHi_q <= busWrData;
      end
      if (wrRLo) begin
        remoteLo_q <= busWrData;
      end
    end
  end

  // Results load only from the converter
  always_ff @(posedge core_clk) begin
    if (rst) begin
      localVal_q  <= tmra_pkg::VAL_RST;
      remoteVal_q <= tmra_pkg::VAL_RST;
      open_q      <= 1'b0;
    end else if (loadRes) begin
      localVal_q  <= adcLocal;
      remoteVal_q <= adcRemote;
      open_q      <= adcOpen;
    end
  end

  // Sticky flags, cause overrides a status-read clear
  genvar gi;
  generate
    for (gi = 0; gi < NF; gi++) begin : g_flag
      tmra_sticky_flag u_flag (
        .core_clk (core_clk),
        .rst      (rst),
        .cause    (cause[gi]),
        .clrReq   (statusRd),
        .flag_q   (flags[gi])
      );
    end
  endgenerate

  // One-shot request, honoured only in standby
  always_ff @(posedge core_clk) begin
    if (rst) begin
      oneShot_q <= 1'b0;
    end else if (shotArm) begin
      oneShot_q <= 1'b1;
    end else if (startReq | ~standby) begin
      oneShot_q <= 1'b0;
    end
  end

  // Pacing counter holds at zero until a start is taken
  always_comb begin
    cnt_d = cnt_q;
    if (standby | (startReq & runDue)) begin
      cnt_d = period - 32'h0000_0001;
    end else if (~cntZero) begin
      cnt_d = cnt_q - 32'h0000_0001;
    end
  end

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      tmra_pkg::CONV_IDLE: begin
        if (startReq) begin
          state_d = tmra_pkg::CONV_BUSY;
        end
      end
      tmra_pkg::CONV_BUSY: begin
        if (adcDone) begin
          state_d = tmra_pkg::CONV_IDLE;
        end
      end
      default: state_d = tmra_pkg::CONV_IDLE;
    endcase
  end

  // Sequencer state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= tmra_pkg::CONV_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Pacing counter, reloaded on each run start
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Start pulse lasts one cycle since busy follows it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      adcStart <= 1'b0;
    end else begin
      adcStart <= startReq;
    end
  end

  // Read strobe, one cycle after the request
  always_ff @(posedge core_clk) begin
    if (rst) begin
      busRdValid <= 1'b0;
    end else begin
      busRdValid <= busRdReq;
    end
  end

  // Read byte holds until the next request
  always_ff @(posedge core_clk) begin
    if (rst) begin
      busRdData <= 8'h00;
    end else if (busRdReq) begin
      busRdData <= rdMux;
    end
  end

  // Strap caught once after reset release
  always_ff @(posedge core_clk) begin
    if (rst) begin
      strapDone_q <= 1'b0;
      devAddr_q   <= tmra_pkg::DEV_ADDR_GND;
    end else if (~strapDone_q) begin
      strapDone_q <= 1'b1;
      devAddr_q   <= strapAddr;
    end
  end

  // Alert response: answer only while pulling the pin
  always_ff @(posedge core_clk) begin
    if (rst) begin
      araValid <= 1'b0;
      araAddr  <= 7'h00;
    end else begin
      araValid <= araTaken;
      if (araTaken) begin
        araAddr <= devAddr_q;
      end
    end
  end

  // Latch survives status reads; needs service plus clean state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      latch_q       <= 1'b0;
      servicePend_q <= 1'b0;
    end else if (|flags) begin
      latch_q <= 1'b1;
      if (araTaken) begin
        servicePend_q <= 1'b1;
      end
    end else if (latch_q) begin
      if (latchClr) begin
        latch_q       <= 1'b0;
        servicePend_q <= 1'b0;
      end else if (araTaken) begin
        servicePend_q <= 1'b1;
      end
    end else begin
      servicePend_q <= 1'b0;
    end
  end

  // Open-drain pin only ever pulls low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      alertPinOut <= 1'b0;
      alertPinOe  <= 1'b0;
    end else begin
      alertPinOut <= 1'b0;
      alertPinOe  <= pullD;
    end
  end
endmodule // tmra_core
`default_nettype wire

// ---- tmra_pkg.sv ----
// Constants of the temperature monitor register and alarm core.
// Assumes one 200 MHz core clock; bytes arrive from a two-wire engine.
//
// What this block does
// - Status bit 7 high while converting
// - Out-of-limit local or remote measurement sets flag
// - Local over flag bit 6, under bit 5
// - Remote over flag bit 4, under bit 3
// - Open sensor sets bit 2; bits 1-0 reserved
// - Any flag sets alarm latch, pulls alarm low
// - Status read clears flags whose cause is gone
// - Flag holds while its cause persists
// - Flags sticky until status read or reset
// - Latch clears after alert response, cause gone
// - Config bit 6: 0 run, 1 standby
// - Low sleep pin forces standby
// - Config bit 7 masks alarm output
// - Rate code divides period: 16 s to 125 ms
// - Strictly greater or strictly less trips alarm
// - Write to 0F runs one standby conversion
// - Local high limit 05/0B, reset 7Fh
// - Local low limit 06/0C, reset C9h
// - Remote limits 07/0D and 08/0E
// - Value registers read-only 00/01, reset zero
// - Values and limits 8-bit two's complement
// - First write byte loads register pointer
// - Separate read and write addresses
// - Alert response returns own device address
package tmra_pkg;
  // Read addresses
  localparam logic [7:0] RD_LOCAL_VAL  = 8'h00;
  localparam logic [7:0] RD_REMOTE_VAL = 8'h01;
  localparam logic [7:0] RD_STATUS     = 8'h02;
  localparam logic [7:0] RD_CFG        = 8'h03;
  localparam logic [7:0] RD_RATE       = 8'h04;
  localparam logic [7:0] RD_LOCAL_HI   = 8'h05;
  localparam logic [7:0] RD_LOCAL_LO   = 8'h06;
  localparam logic [7:0] RD_REMOTE_HI  = 8'h07;
  localparam logic [7:0] RD_REMOTE_LO  = 8'h08;
  localparam logic [7:0] RD_MAKER      = 8'hFE;
  localparam logic [7:0] RD_REVISION   = 8'hFF;
  // Write addresses
  localparam logic [7:0] WR_CFG        = 8'h09;
  localparam logic [7:0] WR_RATE       = 8'h0A;
  localparam logic [7:0] WR_LOCAL_HI   = 8'h0B;
  localparam logic [7:0] WR_LOCAL_LO   = 8'h0C;
  localparam logic [7:0] WR_REMOTE_HI  = 8'h0D;
  localparam logic [7:0] WR_REMOTE_LO  = 8'h0E;
  localparam logic [7:0] WR_ONE_SHOT   = 8'h0F;
  // Field positions
  localparam int ST_BUSY_BIT  = 7;
  localparam int ST_FLAG_LSB  = 2;
  localparam int NUM_FLAGS    = 5;
  localparam int CFG_MASK_BIT = 7;
  localparam int CFG_SLEEP_PIN_N_BIT = 6;
  localparam int RATE_W       = 3;
  // Reset values
  localparam logic [7:0] PTR_RST  = 8'h00;
  localparam logic [7:0] VAL_RST  = 8'h00;
  localparam logic [7:0] CFG_RST  = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h02;
  localparam logic [7:0] HI_RST   = 8'h7F;
  localparam logic [7:0] LO_RST   = 8'hC9;
  localparam logic [7:0] RATE_MAX = 8'h07;
  localparam logic [7:0] RD_INVALID = 8'h00;
  // Device addresses per strap level
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_NC  = 2'h1;
  localparam logic [6:0] DEV_ADDR_GND = 7'h4C;
  localparam logic [6:0] DEV_ADDR_NC  = 7'h4D;
  localparam logic [6:0] DEV_ADDR_VDD = 7'h4E;
  // Timing: fastest conversion period, code 07h
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned FAST_PERIOD_MS = 125;
  localparam int unsigned FAST_PERIOD_CYC = FAST_PERIOD_MS * CLK_MHZ * 1000;
  // Conversion sequencer states
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_BUSY = 2'b01
  } tmra_conv_state_t;
endpackage

// ---- tmra_sticky_flag.sv ----
// One sticky status flag with conditional clear.
// Assumes the cause input is already a registered level.
`timescale 1ns/10ps
`default_nettype none
module tmra_sticky_flag (
  input  wire logic core_clk, // Core clock
  input  wire logic rst,      // Synchronous reset, high
  input  wire logic cause,    // Cause present this cycle
  input  wire logic clrReq,   // Status read clear request
  output logic      flag_q    // Sticky flag
);
  // Cause beats clear, so an event never drops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else if (cause) begin
      flag_q <= 1'b1;
    end else if (clrReq) begin
      flag_q <= 1'b0;
    end
  end
endmodule // tmra_sticky_flag
`default_nettype wire

// ---- tmra_core_sva.sv ----
// Port checker for the register and alarm core.
// Assumes the strap input is held steady for the whole run.
`timescale 1ns/10ps
`default_nettype none
module tmra_core_sva (
  input wire logic       core_clk,    // Clock
  input wire logic       rst,         // Reset
  input wire logic       busRdReq,    // Read request
  input wire logic [7:0] busRdData,   // Read byte
  input wire logic       busRdValid,  // Read valid
  input wire logic       araReq,      // Alert response
  input wire logic       araValid,    // Answer pulse
  input wire logic [6:0] araAddr,     // Own address
  input wire logic       adcStart,    // Start pulse
  input wire logic [1:0] addrStrap,   // Strap level
  input wire logic       alertPinOut, // Pin level
  input wire logic       alertPinOe   // Pin enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  wire [6:0] expAddr;
  // Address expected from the strap level
  assign expAddr = (addrStrap == 2'h0) ? tmra_pkg::DEV_ADDR_GND :
                   (addrStrap == 2'h1) ? tmra_pkg::DEV_ADDR_NC : tmra_pkg::DEV_ADDR_VDD;
  sequence s_araTaken;
    araReq && alertPinOe;
  endsequence
  sequence s_araAnswer;
    araValid && (araAddr == expAddr);
  endsequence
  property p_rdAns; busRdReq |=> busRdValid; endproperty
  property p_rdQuiet; !busRdReq |=> !busRdValid; endproperty
  property p_rdHold; !busRdValid |-> $stable(busRdData); endproperty
  property p_araAns; s_araTaken |=> s_araAnswer; endproperty
  property p_araQuiet; !(araReq && alertPinOe) |=> !araValid; endproperty
  property p_araPull; araValid |-> alertPinOe; endproperty
  property p_pinLow; alertPinOut == 1'b0; endproperty
  property p_startPulse; adcStart |=> !adcStart; endproperty
  a_rdAns: assert property (p_rdAns) else $error("read not answered next cycle");
  a_rdQuiet: assert property (p_rdQuiet) else $error("read valid without request");
  a_rdHold: assert property (p_rdHold) else $error("read data moved");
  a_araAns: assert property (p_araAns) else $error("alert response wrong");
  a_araQuiet: assert property (p_araQuiet) else $error("alert answer unasked");
  a_araPull: assert property (p_araPull) else $error("latch dropped early");
  a_pinLow: assert property (p_pinLow) else $error("alarm pin drives high");
  a_startPulse: assert property (p_startPulse) else $error("start pulse too long");
endmodule // tmra_core_sva
bind tmra_core tmra_core_sva u_sva (.core_clk(core_clk), .rst(rst), .busRdReq(busRdReq),
  .busRdData(busRdData), .busRdValid(busRdValid), .araReq(araReq), .araValid(araValid),
  .araAddr(araAddr), .adcStart(adcStart), .addrStrap(addrStrap), .alertPinOut(alertPinOut),
  .alertPinOe(alertPinOe));
`default_nettype wire

// ---- tmra_adc_model.sv ----
// Converter model answering each start after a fixed delay.
// Assumes starts arrive only while the core is idle.
`timescale 1ns/10ps
`default_nettype none
module tmra_adc_model #(
  parameter int LAT = 8 // Start to done
) (
  input  wire logic       core_clk,  // Clock
  input  wire logic       rst,       // Reset
  input  wire logic       adcStart,  // Start pulse
  input  wire logic [7:0] locIn,     // Local reading
  input  wire logic [7:0] remIn,     // Remote reading
  input  wire logic       openIn,    // Open junction
  output logic            adcDone,   // Done pulse
  output logic      [7:0] adcLocal,  // Local result
  output logic      [7:0] adcRemote, // Remote result
  output logic            adcOpen    // Open result
);
  int cnt_q;
  // Countdown from start to done
  always_ff @(posedge core_clk) begin
    if (rst) cnt_q <= 0;
    else if (adcStart) cnt_q <= LAT;
    else if (cnt_q != 0) cnt_q <= cnt_q - 1;
  end
  assign adcDone = (cnt_q == 1);
  // Inverted outside done, so a core sampling late sees garbage
  assign adcLocal  = adcDone ? locIn : ~locIn;
  assign adcRemote = adcDone ? remIn : ~remIn;
  assign adcOpen   = adcDone ? openIn : ~openIn;
endmodule // tmra_adc_model
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the register and alarm core.
// Assumes the strap is tied to ground level.
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam logic [7:0] MK = 8'h5A; // Arbitrary maker value
  localparam int FC = 20;            // Short pacing count
  logic core_clk = 1'b0;
  logic rst, busWrValid, busWrFirst, busRdReq, araReq, sleepPinN, openIn;
  logic busRdValid, araValid, adcStart, adcDone, adcOpen, alertPinOut, alertPinOe;
  logic [7:0] busWrData, busRdData, locIn, remIn, adcLocal, adcRemote, d;
  logic [6:0] araAddr;
  int err_total = 0, compares = 0, cyc = 0, nStart = 0, t0, n0;
  logic [7:0] rA [10] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0B, 8'hFE};
  logic [7:0] rE [10] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h7F, 8'hC9, 8'h7F, 8'hC9, 8'h00, MK};
  logic [7:0] cL [5] = '{8'h32, 8'h33, 8'hC9, 8'hC8, 8'h00};
  logic [7:0] cR [5] = '{8'h10, 8'h10, 8'hC9, 8'h11, 8'hC8};
  logic [7:0] cE [5] = '{8'h00, 8'h40, 8'h00, 8'h30, 8'h0C};
  always #2.5 core_clk = ~core_clk;
  // Cycle and start counts for pacing checks
  always @(posedge core_clk) begin
    cyc++;
    if (adcStart === 1'b1) nStart++;
  end
  tmra_core #(.FAST_CYCLES(FC), .MAKER_ID(MK)) dut (.core_clk(core_clk), .rst(rst),
    .busWrValid(busWrValid), .busWrFirst(busWrFirst), .busWrData(busWrData), .busRdReq(busRdReq),
    .busRdData(busRdData), .busRdValid(busRdValid), .araReq(araReq), .araValid(araValid),
    .araAddr(araAddr), .adcStart(adcStart), .adcDone(adcDone), .adcLocal(adcLocal),
    .adcRemote(adcRemote), .adcOpen(adcOpen), .sleep_pin_n(sleepPinN), .addrStrap(2'h0),
    .alertPinOut(alertPinOut), .alertPinOe(alertPinOe));
  tmra_adc_model u_adc (.core_clk(core_clk), .rst(rst), .adcStart(adcStart), .locIn(locIn),
    .remIn(remIn), .openIn(openIn), .adcDone(adcDone), .adcLocal(adcLocal),
    .adcRemote(adcRemote), .adcOpen(adcOpen));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Pointer byte, then an optional data byte to the same pointer
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input bit dat);
    @(posedge core_clk) #1;
    busWrValid = 1'b1;
    busWrFirst = 1'b1;
    busWrData = a;
    if (dat) begin
      @(posedge core_clk) #1;
      busWrFirst = 1'b0;
      busWrData = v;
    end
    @(posedge core_clk) #1;
    busWrValid = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    wr(a, 8'h00, 1'b0);
    busRdReq = 1'b1;
    @(posedge core_clk) #1;
    busRdReq = 1'b0;
    chk({7'h00, busRdValid}, 8'h01);
    v = busRdData;
  endtask
  task automatic ara(input bit want);
    @(posedge core_clk) #1;
    araReq = 1'b1;
    @(posedge core_clk) #1;
    araReq = 1'b0;
    chk({7'h00, araValid}, {7'h00, want});
    if (want) chk({1'b0, araAddr}, {1'b0, tmra_pkg::DEV_ADDR_GND});
  endtask
  // Bounded wait for the next start pulse
  task automatic ws();
    int n;
    n = 0;
    do begin
      @(posedge core_clk) #1;
      n++;
    end while (adcStart !== 1'b1 && n < 3000);
    chk({7'h00, adcStart}, 8'h01);
  endtask
  task automatic results();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #300000;
    err_total++;
    results();
  end
  initial begin
    {rst, busWrValid, busWrFirst, busRdReq, araReq, openIn} = 6'b100000;
    {busWrData, locIn, remIn} = 24'h000000;
    sleepPinN = 1'b1;
    repeat (5) @(posedge core_clk);
    #1 rst = 1'b0;
    foreach (rA[i]) begin
      rd(rA[i], d);
      chk(d, rE[i]);
    end
    wr(tmra_pkg::RD_LOCAL_HI, 8'h11, 1'b1);
    rd(tmra_pkg::RD_LOCAL_HI, d);
    chk(d, 8'h7F);
    wr(tmra_pkg::WR_RATE, 8'hFF, 1'b1);
    rd(tmra_pkg::RD_RATE, d);
    chk(d, 8'h07);
    wr(tmra_pkg::WR_CFG, 8'hFF, 1'b1);
    rd(tmra_pkg::RD_CFG, d);
    chk(d, 8'hC0);
    wr(tmra_pkg::WR_CFG, 8'h00, 1'b1);
    wr(tmra_pkg::WR_LOCAL_HI, 8'h32, 1'b1);
    wr(tmra_pkg::WR_REMOTE_HI, 8'h10, 1'b1);
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      locIn = cL[i];
      remIn = cR[i];
      openIn = (i == 4);
      repeat (60) @(posedge core_clk);
      rd(tmra_pkg::RD_STATUS, d);
      chk(d & 8'h7F, cE[i] | ((i > 0) ? cE[i - 1] : 8'h00));
      rd(tmra_pkg::RD_STATUS, d);
      chk(d & 8'h7F, cE[i]);
    end
    chk({7'h00, alertPinOe}, 8'h01);
    chk({7'h00, alertPinOut}, 8'h00);
    {locIn, remIn, openIn} = 17'h00000;
    repeat (60) @(posedge core_clk);
    rd(tmra_pkg::RD_STATUS, d);
    rd(tmra_pkg::RD_STATUS, d);
    chk(d & 8'h7F, 8'h00);
    chk({7'h00, alertPinOe}, 8'h01);
    ara(1'b1);
    repeat (3) @(posedge core_clk);
    chk({7'h00, alertPinOe}, 8'h00);
    ara(1'b0);
    wr(tmra_pkg::WR_CFG, 8'h80, 1'b1);
    locIn = 8'h33;
    repeat (60) @(posedge core_clk);
    chk({7'h00, alertPinOe}, 8'h00);
    wr(tmra_pkg::WR_CFG, 8'h00, 1'b1);
    repeat (5) @(posedge core_clk);
    chk({7'h00, alertPinOe}, 8'h01);
    $display("test alarm done");
    for (int c = 5; c < 8; c++) begin
      wr(tmra_pkg::WR_RATE, 8'(c), 1'b1);
      ws();
      ws();
      t0 = cyc;
      ws();
      chk(8'(cyc - t0), 8'(FC << (7 - c)));
    end
    $display("test rate done");
    for (int m = 0; m < 2; m++) begin
      if (m == 0) sleepPinN = 1'b0;
      else wr(tmra_pkg::WR_CFG, 8'h40, 1'b1);
      sleepPinN = (m == 1);
      repeat (40) @(posedge core_clk);
      n0 = nStart;
      repeat (100) @(posedge core_clk);
      chk(8'(nStart - n0), 8'h00);
      wr(tmra_pkg::WR_ONE_SHOT, 8'hA5, 1'b1);
      ws();
      rd(tmra_pkg::RD_STATUS, d);
      chk({7'h00, d[7]}, 8'h01);
      repeat (20) @(posedge core_clk);
      rd(tmra_pkg::RD_STATUS, d);
      chk({7'h00, d[7]}, 8'h00);
      chk(8'(nStart - n0), 8'h01);
    end
    $display("test standby done");
    results();
  end
endmodule // tb
`default_nettype wire
